// >>> logic/sleep_mode_control.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module sleep_mode_control
  import sleep_ctl_pkg::*;
(
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  // AXI4-Lite slave
  input  wire logic [sleep_ctl_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [sleep_ctl_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [sleep_ctl_pkg::STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [sleep_ctl_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [sleep_ctl_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // cpu core side
  input  wire logic                              wfiExec,
  input  wire logic [sleep_ctl_pkg::IRQ_COUNT-1:0] irqPin,
  input  wire logic [sleep_ctl_pkg::RST_COUNT-1:0] resetSourcePin,
  input  wire logic [sleep_ctl_pkg::DATA_W-1:0]  optionWordIn,
  input  wire logic                              variantSecondPin,
  output logic                                   cpuClockStop,
  output logic                                   resumeIrq,
  output logic [sleep_ctl_pkg::IRQ_ID_W-1:0]     resumeIrqId,
  output logic                                   resetStateReq,
  output logic                                   indepWatchdogRun,
  output logic                                   watchdogRun,
  output logic                                   gainAmpEnable
);
  import sleep_ctl_pkg::*;

  // ============================================================
  // pin synchronisers
  logic [IRQ_COUNT-1:0] irqSync;
  logic [RST_COUNT-1:0] rstSync;
  logic                 variantSync;

  sync_two_ff #(.WIDTH(IRQ_COUNT + RST_COUNT + 1)) u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .asyncIn ({variantSecondPin, resetSourcePin, irqPin}),
    .syncOut ({variantSync, rstSync, irqSync})
  );

  // ============================================================
  // straps: caught by clock after reset release, never by the reset itself
  logic              strapsTaken;
  logic [DATA_W-1:0] optionWord;
  logic              variantSecond;
  logic              next_strapsTaken;
  logic [DATA_W-1:0] next_optionWord;
  logic              next_variantSecond;

  always_comb
  begin
    next_strapsTaken   = 1'b1;
    next_optionWord    = strapsTaken ? optionWord : optionWordIn;
    // strap is static; following the synchroniser avoids latching its reset zero
    next_variantSecond = variantSync;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      strapsTaken   <= 1'b0;
      optionWord    <= ZERO_WORD;
      variantSecond <= 1'b0;
    end
    else
    begin
      strapsTaken   <= next_strapsTaken;
      optionWord    <= next_optionWord;
      variantSecond <= next_variantSecond;
    end
  end

  // ============================================================
  // register file
  logic [DATA_W-1:0] standbyControlReg;
  logic [DATA_W-1:0] moduleStopD;
  logic [DATA_W-1:0] statusWord;
  logic              wokeByIrq;
  logic              wokeByRst;
  logic [IRQ_ID_W-1:0] lastIrqId;
  logic              standbySelectBit;

  assign standbySelectBit = standbyControlReg[STANDBY_SELECT_POS];

  // ============================================================
  // sleep sequencer
  sleep_state_t        state;
  sleep_state_t        next_state;
  logic                next_cpuClockStop;
  logic                next_resumeIrq;
  logic [IRQ_ID_W-1:0] next_resumeIrqId;
  logic                next_resetStateReq;
  logic                next_wokeByIrq;
  logic                next_wokeByRst;
  logic [IRQ_ID_W-1:0] pickId;
  logic                anyIrq;
  logic                anyRst;

  always_comb
  begin
    // lowest numbered pending line is serviced first
    pickId = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--)
    begin
      if (irqSync[i])
      begin
        pickId = IRQ_ID_W'(i);
      end
    end
    anyIrq = |irqSync;
    anyRst = |rstSync;
  end

  always_comb
  begin
    next_state         = state;
    next_resumeIrq     = 1'b0;
    next_resumeIrqId   = resumeIrqId;
    next_resetStateReq = anyRst;
    next_wokeByIrq     = wokeByIrq;
    next_wokeByRst     = wokeByRst;
    case (state)
      ST_RUN:
      begin
        if (wfiExec && !standbySelectBit)                             // [RULE1]
        begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        // reset outranks an interrupt arriving in the same cycle
        if (anyRst)                                                   // [RULE2]
        begin
          next_state     = ST_WAKE_RST;
          next_wokeByRst = 1'b1;
          next_wokeByIrq = 1'b0;
        end
        else if (anyIrq)                                              // [RULE3]
        begin
          next_state       = ST_WAKE_IRQ;
          next_resumeIrq   = 1'b1;
          next_resumeIrqId = pickId;
          next_wokeByIrq   = 1'b1;
          next_wokeByRst   = 1'b0;
        end
      end
      ST_WAKE_IRQ:
      begin
        next_state = ST_RUN;                                          // [RULE3]
      end
      ST_WAKE_RST:
      begin
        // held until the source drops so the program never resumes
        next_resetStateReq = 1'b1;                                    // [RULE4]
        if (!anyRst)
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
    next_cpuClockStop = (next_state == ST_SLEEP);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state         <= ST_RUN;
      cpuClockStop  <= 1'b0;
      resumeIrq     <= 1'b0;
      resumeIrqId   <= '0;
      resetStateReq <= 1'b0;
      wokeByIrq     <= 1'b0;
      wokeByRst     <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cpuClockStop  <= next_cpuClockStop;
      resumeIrq     <= next_resumeIrq;
      resumeIrqId   <= next_resumeIrqId;
      resetStateReq <= next_resetStateReq;
      wokeByIrq     <= next_wokeByIrq;
      wokeByRst     <= next_wokeByRst;
    end
  end

  assign lastIrqId = resumeIrqId;

  // ============================================================
  // watchdog and amplifier gating
  logic next_indepWatchdogRun;
  logic next_watchdogRun;
  logic next_gainAmpEnable;

  always_comb
  begin
    // outside auto-start mode sleep leaves the watchdogs alone
    next_indepWatchdogRun = !(next_cpuClockStop && optionWord[OPT_IWDG_AUTO_POS]
                              && optionWord[OPT_IWDG_STOP_POS]);      // [RULE5]
    next_watchdogRun      = !(next_cpuClockStop && optionWord[OPT_WDG_AUTO_POS]
                              && optionWord[OPT_WDG_STOP_POS]);       // [RULE6]
    if (variantSecond)
    begin
      next_gainAmpEnable = !moduleStopD[MSTP_D_AMP_HIGH_POS];         // [RULE8]
    end
    else
    begin
      next_gainAmpEnable = !moduleStopD[MSTP_D_AMP_HIGH_POS]
                           && !moduleStopD[MSTP_D_AMP_LOW_POS];       // [RULE7]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      indepWatchdogRun <= 1'b1;
      watchdogRun      <= 1'b1;
      gainAmpEnable    <= 1'b0;
    end
    else
    begin
      indepWatchdogRun <= next_indepWatchdogRun;
      watchdogRun      <= next_watchdogRun;
      gainAmpEnable    <= next_gainAmpEnable;
    end
  end

  always_comb
  begin
    statusWord = ZERO_WORD;
    statusWord[STAT_SLEEPING_POS] = cpuClockStop;
    statusWord[STAT_IWDG_RUN_POS] = indepWatchdogRun;
    statusWord[STAT_WDG_RUN_POS]  = watchdogRun;
    statusWord[STAT_AMP_ON_POS]   = gainAmpEnable;
    statusWord[STAT_VARIANT_POS]  = variantSecond;
    statusWord[STAT_WOKE_IRQ_POS] = wokeByIrq;
    statusWord[STAT_WOKE_RST_POS] = wokeByRst;
    statusWord[STAT_IRQ_ID_POS +: IRQ_ID_W] = lastIrqId;
  end

  // ============================================================
  // AXI4-Lite slave: one write and one read in flight
  logic              awHeld, wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [DATA_W-1:0] wData;
  logic [STRB_W-1:0] wStrb;
  logic              next_awHeld, next_wHeld, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_awAddr;
  logic [DATA_W-1:0] next_wData, next_rdata;
  logic [STRB_W-1:0] next_wStrb;
  logic [1:0]        next_bresp, next_rresp;
  logic [DATA_W-1:0] next_standbyControlReg, next_moduleStopD, byteMask;
  logic              doWrite;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    next_awAddr = awAddr;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_standbyControlReg = standbyControlReg;
    next_moduleStopD       = moduleStopD;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    for (int b = 0; b < STRB_W; b++)
    begin
      byteMask[b*8 +: 8] = {8{wStrb[b]}};
    end
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      case (awAddr)
        OFF_STANDBY_CTRL: next_standbyControlReg = (standbyControlReg & ~(byteMask & STANDBY_CTRL_MSK))
                                                   | (wData & byteMask & STANDBY_CTRL_MSK);
        OFF_MODULE_STOP:  next_moduleStopD = (moduleStopD & ~(byteMask & MODULE_STOP_MSK))
                                             | (wData & byteMask & MODULE_STOP_MSK);
        OFF_OPTION_WORD0: next_bresp = RESP_OKAY;
        OFF_SLEEP_STATUS: next_bresp = RESP_OKAY;
        default:          next_bresp = RESP_SLVERR;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFF_STANDBY_CTRL: next_rdata = standbyControlReg;
        OFF_MODULE_STOP:  next_rdata = moduleStopD;
        OFF_OPTION_WORD0: next_rdata = optionWord;
        OFF_SLEEP_STATUS: next_rdata = statusWord;
        default:
        begin
          next_rdata = ZERO_WORD;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      awHeld            <= 1'b0;
      wHeld             <= 1'b0;
      awAddr            <= '0;
      wData             <= ZERO_WORD;
      wStrb             <= '0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= RESP_OKAY;
      s_axi_rvalid      <= 1'b0;
      s_axi_rdata       <= ZERO_WORD;
      s_axi_rresp       <= RESP_OKAY;
      standbyControlReg <= STANDBY_CTRL_RST;
      moduleStopD       <= MODULE_STOP_RST;
    end
    else
    begin
      awHeld            <= next_awHeld;
      wHeld             <= next_wHeld;
      awAddr            <= next_awAddr;
      wData             <= next_wData;
      wStrb             <= next_wStrb;
      s_axi_bvalid      <= next_bvalid;
      s_axi_bresp       <= next_bresp;
      s_axi_rvalid      <= next_rvalid;
      s_axi_rdata       <= next_rdata;
      s_axi_rresp       <= next_rresp;
      standbyControlReg <= next_standbyControlReg;
      moduleStopD       <= next_moduleStopD;
    end
  end
endmodule

// >>> shared/sleep_ctl_pkg.sv
// Summary of operation
// RULE1 - WFI with standby-select clear enters sleep
// RULE2 - any available reset source ends sleep
// RULE3 - interrupt ends sleep, resume servicing it
// RULE4 - reset-ended sleep goes to reset state
// RULE5 - auto-start: stop bit halts independent watchdog, oscillator (no oscillator control here; only indepWatchdogRun is gated)
// RULE6 - auto-start: stop bit halts regular watchdog
// RULE7 - first variant: clear module-stop bits 15, 16
// RULE8 - second variant: clear module-stop bit 16 only
package sleep_ctl_pkg;
  // ============================================================
  // sizes
  localparam int IRQ_COUNT   = 16;
  localparam int IRQ_ID_W    = 4;
  localparam int RST_COUNT   = 4;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int STRB_W      = 4;

  // ============================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_STANDBY_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODULE_STOP  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OPTION_WORD0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_STATUS = 8'h0C;

  // ============================================================
  // field positions
  localparam int STANDBY_SELECT_POS      = 15;
  localparam int MSTP_D_AMP_LOW_POS      = 15;
  localparam int MSTP_D_AMP_HIGH_POS     = 16;
  localparam int OPT_IWDG_AUTO_POS       = 1;
  localparam int OPT_IWDG_STOP_POS       = 14;
  localparam int OPT_WDG_AUTO_POS        = 17;
  localparam int OPT_WDG_STOP_POS        = 30;
  localparam int STAT_SLEEPING_POS       = 0;
  localparam int STAT_IWDG_RUN_POS       = 1;
  localparam int STAT_WDG_RUN_POS        = 2;
  localparam int STAT_AMP_ON_POS         = 3;
  localparam int STAT_VARIANT_POS        = 4;
  localparam int STAT_WOKE_IRQ_POS       = 5;
  localparam int STAT_WOKE_RST_POS       = 6;
  localparam int STAT_IRQ_ID_POS         = 8;

  // ============================================================
  // reset values and masks
  localparam logic [DATA_W-1:0] STANDBY_CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STANDBY_CTRL_MSK = 32'h0000_8000;
  localparam logic [DATA_W-1:0] MODULE_STOP_RST  = 32'h0001_8000;
  localparam logic [DATA_W-1:0] MODULE_STOP_MSK  = 32'h0001_8000;
  localparam logic [DATA_W-1:0] ZERO_WORD        = 32'h0000_0000;

  // ============================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ============================================================
  // sleep sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_IRQ,
    ST_WAKE_RST
  } sleep_state_t;
endpackage

// >>> logic/sync_two_ff.sv
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // ============================================================
  // two stages; the first is read by the second only
  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] next_stageOne;
  logic [WIDTH-1:0] next_syncOut;

  always_comb
  begin
    next_stageOne = asyncIn;
    next_syncOut  = stageOne;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stageOne <= '0;
      syncOut  <= '0;
    end
    else
    begin
      stageOne <= next_stageOne;
      syncOut  <= next_syncOut;
    end
  end
endmodule

// >>> sim/sleep_mode_control_assertions.sv
module sleep_mode_control_checker
  import sleep_ctl_pkg::*;
(
  input wire logic                                 clk_sys,
  input wire logic                                 reset,
  input wire logic [sleep_ctl_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input wire logic                                 s_axi_awvalid,
  input wire logic                                 s_axi_awready,
  input wire logic [sleep_ctl_pkg::DATA_W-1:0]     s_axi_wdata,
  input wire logic                                 s_axi_wvalid,
  input wire logic                                 s_axi_wready,
  input wire logic                                 wfiExec,
  input wire logic [sleep_ctl_pkg::IRQ_COUNT-1:0]  irqPin,
  input wire logic [sleep_ctl_pkg::RST_COUNT-1:0]  resetSourcePin,
  input wire logic [sleep_ctl_pkg::DATA_W-1:0]     optionWordIn,
  input wire logic                                 cpuClockStop,
  input wire logic                                 resumeIrq,
  input wire logic                                 resetStateReq,
  input wire logic                                 indepWatchdogRun,
  input wire logic                                 watchdogRun
);
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_ctl_pkg::*;
  // ==========================================================
  // shadow of the standby-select bit, seen from the bus
  logic sel;
  logic next_sel;
  always_comb
  begin
    next_sel = sel;
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == OFF_STANDBY_CTRL)
      next_sel = s_axi_wdata[STANDBY_SELECT_POS];
  end
  always_ff @(posedge clk_sys)
    sel <= reset ? 1'b0 : next_sel;
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_wfi_enters: assert property (wfiExec && !sel && !cpuClockStop && !$past(cpuClockStop) && !resumeIrq
    && !resetStateReq && !$past(resetStateReq) && !(|irqPin) && !(|resetSourcePin) |=> cpuClockStop)
    else $error("wfi did not stop the cpu clock");
  chk_select_blocks: assert property (wfiExec && sel && !cpuClockStop |=> !cpuClockStop)
    else $error("wfi with standby select set entered sleep");
  chk_irq_wakes: assert property (cpuClockStop && |irqPin && !(|resetSourcePin)
    |-> ##[1:4] (!cpuClockStop && resumeIrq))
    else $error("interrupt did not end sleep with resume");
  chk_resume_pulse: assert property (resumeIrq |=> !resumeIrq)
    else $error("resume pulse longer than one cycle");
  chk_reset_wakes: assert property (cpuClockStop && |resetSourcePin
    |-> ##[1:4] (!cpuClockStop && resetStateReq && !resumeIrq))
    else $error("reset source did not end sleep into reset state");
  chk_reset_request: assert property (|resetSourcePin |-> ##[1:4] resetStateReq)
    else $error("reset source not passed on");
  chk_reset_holds: assert property (resetStateReq && |resetSourcePin |=> resetStateReq && !resumeIrq)
    else $error("reset state dropped while source present");
  chk_dogs_awake: assert property (!cpuClockStop && !$past(cpuClockStop) |-> indepWatchdogRun && watchdogRun)
    else $error("watchdog halted outside sleep");
  chk_iwdg_sleep: assert property (cpuClockStop && $past(cpuClockStop) |-> indepWatchdogRun
    == !(optionWordIn[OPT_IWDG_AUTO_POS] && optionWordIn[OPT_IWDG_STOP_POS]))
    else $error("independent watchdog sleep state wrong");
  chk_wdg_sleep: assert property (cpuClockStop && $past(cpuClockStop) |-> watchdogRun
    == !(optionWordIn[OPT_WDG_AUTO_POS] && optionWordIn[OPT_WDG_STOP_POS]))
    else $error("watchdog sleep state wrong");
endmodule

bind sleep_mode_control sleep_mode_control_checker i_sleep_mode_control_checker (.clk_sys, .reset,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .wfiExec,
  .irqPin, .resetSourcePin, .optionWordIn, .cpuClockStop, .resumeIrq, .resetStateReq, .indepWatchdogRun,
  .watchdogRun);

// >>> sim/cpu_irq_source.sv
module cpu_irq_source
  import sleep_ctl_pkg::*;
(
  input  wire logic                                clk_sys,
  input  wire logic                                resumeIrq,
  input  wire logic [sleep_ctl_pkg::IRQ_ID_W-1:0]  resumeIrqId,
  output logic                                     wfiExec,
  output logic [sleep_ctl_pkg::IRQ_COUNT-1:0]      irqPin,
  output logic [sleep_ctl_pkg::RST_COUNT-1:0]      resetSourcePin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wfiExec = 1'b0;
    irqPin = '0;
    resetSourcePin = '0;
  end
  // the core services the woken interrupt, so that request is withdrawn
  always @(posedge clk_sys)
    if (resumeIrq)
      irqPin[resumeIrqId] <= 1'b0;
  task automatic do_wfi();
    @(posedge clk_sys);
    wfiExec <= 1'b1;
    @(posedge clk_sys);
    wfiExec <= 1'b0;
  endtask
  task automatic set_irqs(input logic [IRQ_COUNT-1:0] v);
    @(posedge clk_sys);
    irqPin <= v;
  endtask
  task automatic set_rst(input logic [RST_COUNT-1:0] v);
    @(posedge clk_sys);
    resetSourcePin <= v;
  endtask
endmodule

// >>> sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_ctl_pkg::*;
  // arbitrary option word for the plain runs
  localparam logic [DATA_W-1:0] OPT    = 32'hA5C3_0F81;
  localparam logic [DATA_W-1:0] MS [3] = '{32'h0001_0000, 32'h0000_8000, 32'h0000_0000};
  logic                 clk_sys = 1'b0;
  logic                 reset = 1'b1;
  logic [ADDR_W-1:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0]    s_axi_wdata = '0, optionWordIn = '0, s_axi_rdata;
  logic [STRB_W-1:0]    s_axi_wstrb = '0;
  logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 variantSecondPin = 0, wfiExec, cpuClockStop, resumeIrq, resetStateReq;
  logic                 indepWatchdogRun, watchdogRun, gainAmpEnable;
  logic [IRQ_COUNT-1:0] irqPin;
  logic [RST_COUNT-1:0] resetSourcePin;
  logic [IRQ_ID_W-1:0]  resumeIrqId;
  int                   n_mismatch = 0, checks = 0;
  sleep_mode_control i_sleep_mode_control (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wfiExec, .irqPin, .resetSourcePin, .optionWordIn, .variantSecondPin, .cpuClockStop, .resumeIrq,
    .resumeIrqId, .resetStateReq, .indepWatchdogRun, .watchdogRun, .gainAmpEnable);
  cpu_irq_source i_cpu_irq_source (.clk_sys, .resumeIrq, .resumeIrqId, .wfiExec, .irqPin, .resetSourcePin);
  initial
    forever #2 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset(input logic [DATA_W-1:0] opt, input logic v);
    @(posedge clk_sys);
    reset <= 1'b1;
    optionWordIn <= opt;
    variantSecondPin <= v;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
    logic got;
    got = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!got)
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
      @(posedge clk_sys);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge clk_sys);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    if (exp !== 'x)
      check(s_axi_rdata, exp);
    check(s_axi_rresp, er);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_regs();
    logic [1:0] r;
    rchk(OFF_STANDBY_CTRL, STANDBY_CTRL_RST, RESP_OKAY);
    rchk(OFF_MODULE_STOP, MODULE_STOP_RST, RESP_OKAY);
    rchk(OFF_OPTION_WORD0, OPT, RESP_OKAY);
    rchk(8'h10, ZERO_WORD, RESP_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, r);
    check(r, RESP_SLVERR);
    wr(OFF_OPTION_WORD0, ZERO_WORD, r);
    check(r, RESP_OKAY);
    rchk(OFF_OPTION_WORD0, OPT, RESP_OKAY);
    wr(OFF_STANDBY_CTRL, 32'hFFFF_FFFF, r);
    rchk(OFF_STANDBY_CTRL, STANDBY_CTRL_MSK, RESP_OKAY);
    wr(OFF_STANDBY_CTRL, ZERO_WORD, r);
  endtask
  // software side: which module-stop bits it clears decides the amplifiers
  task automatic s_amp();
    logic [1:0] r;
    for (int v = 0; v < 2; v++)
    begin
      do_reset(OPT, v[0]);
      check(gainAmpEnable, 1'b0);
      foreach (MS[i])
      begin
        wr(OFF_MODULE_STOP, MS[i], r);
        settle();
        check(gainAmpEnable, v ? !MS[i][16] : MS[i] == 0);
      end
    end
  endtask
  task automatic s_block();
    logic [1:0] r;
    wr(OFF_STANDBY_CTRL, STANDBY_CTRL_MSK, r);
    i_cpu_irq_source.do_wfi();
    settle();
    check(cpuClockStop, 1'b0);
    wr(OFF_STANDBY_CTRL, ZERO_WORD, r);
  endtask
  task automatic s_irq();
    i_cpu_irq_source.do_wfi();
    settle();
    check(cpuClockStop, 1'b1);
    i_cpu_irq_source.set_irqs(16'h0220);
    wait (resumeIrq);
    #1;
    check(cpuClockStop, 1'b0);
    check(resumeIrqId, 4'h5);
    check(resetStateReq, 1'b0);
    i_cpu_irq_source.set_irqs(16'h0000);
    settle();
    rchk(OFF_SLEEP_STATUS, 32'h0000_0526, RESP_OKAY);
  endtask
  task automatic s_rst();
    for (int k = 0; k < RST_COUNT; k++)
    begin
      i_cpu_irq_source.do_wfi();
      settle();
      i_cpu_irq_source.set_rst(4'h1 << k);
      wait (resetStateReq);
      #1;
      check(cpuClockStop, 1'b0);
      check(resumeIrq, 1'b0);
      i_cpu_irq_source.set_rst(4'h0);
      wait (!resetStateReq);
      rchk(OFF_SLEEP_STATUS, k ? 32'h0000_0046 : 32'h0000_0546, RESP_OKAY);
      do_reset(OPT, 1'b0);
    end
  endtask
  task automatic s_dogs();
    logic [DATA_W-1:0] opt;
    for (int i = 0; i < 5; i++)
    begin
      opt = ZERO_WORD;
      opt[OPT_IWDG_AUTO_POS] = i[0] || i == 4;
      opt[OPT_WDG_AUTO_POS] = i[1] || i == 4;
      opt[OPT_IWDG_STOP_POS] = i < 4;
      opt[OPT_WDG_STOP_POS] = i < 4;
      do_reset(opt, 1'b0);
      i_cpu_irq_source.do_wfi();
      settle();
      check(indepWatchdogRun, !(i[0] && i < 4));
      check(watchdogRun, !(i[1] && i < 4));
      i_cpu_irq_source.set_irqs(16'h8000);
      wait (resumeIrq);
      #1;
      check(resumeIrqId, 4'hF);
      check(watchdogRun && indepWatchdogRun, 1'b1);
    end
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    do_reset(OPT, 1'b0);
    s_regs();
    s_amp();
    do_reset(OPT, 1'b0);
    s_block();
    s_irq();
    s_rst();
    s_dogs();
    wrap_up();
  end
  // the whole run needs a few hundred cycles; this cuts a hung wait
  initial
  begin
    #40000;
    n_mismatch++;
    wrap_up();
  end
endmodule
